// ### rtl/ccpts_pkg.sv
// Purpose: constants and types of the capture/compare/pwm timer source select
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   shared by the top module and the per-unit decoder
//
// Overview of operation
// RULE1 - four 2-bit selectors packed in one byte
// RULE2 - capture/compare, selector low bit one: second 16-bit timer
// RULE3 - capture/compare, selector low bit zero: first 16-bit timer
// RULE4 - pwm, selector 10: third 8-bit period timer
// RULE5 - pwm, selector 01: second 8-bit period timer
// RULE6 - software avoids selector 11 in pwm
// RULE7 - pwm, selector 00: first 8-bit period timer
// RULE8 - unit mode field decides capture, compare or pwm
`default_nettype none

package ccpts_pkg;

  // widths
  localparam int unsigned NUM_UNITS = 4;     // units served by this register
  localparam int unsigned SEL_W     = 2;     // selector field width
  localparam int unsigned MODE_W    = 4;     // unit mode field width
  localparam int unsigned ADDR_W    = 8;     // register bus address width
  localparam int unsigned DATA_W    = 8;     // register bus data width
  localparam int unsigned T16_W     = 16;    // wide timer width
  localparam int unsigned T8_W      = 8;     // period timer width

  // register offsets
  localparam logic [7:0] OFS_SEL    = 8'h00;  // unit1_to_4_timer_source_select
  localparam logic [7:0] OFS_CLASS  = 8'h01;  // mode class of each unit
  localparam logic [7:0] OFS_SRC    = 8'h02;  // 16-bit choice and reserved flags

  // reset values
  localparam logic [7:0] SEL_RESET  = 8'h00;  // all units on their first timers

  // selector field positions (low bit of each field)
  localparam int unsigned UNIT1_SEL_LSB = 0;
  localparam int unsigned UNIT2_SEL_LSB = 2;
  localparam int unsigned UNIT3_SEL_LSB = 4;
  localparam int unsigned UNIT4_SEL_LSB = 6;

  // status field positions
  localparam int unsigned CLASS_PWM_LSB = 0;  // pwm flags, one per unit
  localparam int unsigned CLASS_CC_LSB  = 4;  // capture/compare flags
  localparam int unsigned SRC_SEC_LSB   = 0;  // second 16-bit timer in use
  localparam int unsigned SRC_RSV_LSB   = 4;  // sticky reserved-code flags

  // pwm selector codes
  localparam logic [1:0] PWM_SEL_FIRST  = 2'h0;
  localparam logic [1:0] PWM_SEL_SECOND = 2'h1;
  localparam logic [1:0] PWM_SEL_THIRD  = 2'h2;
  localparam logic [1:0] PWM_SEL_RSV    = 2'h3;

  // mode field codes
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;

  // unit operating class
  typedef enum logic [2:0] {
    CCPTS_CLS_OFF,
    CCPTS_CLS_CAPTURE,
    CCPTS_CLS_COMPARE,
    CCPTS_CLS_PWM,
    CCPTS_CLS_RESERVED
  } ccpts_class_t;

endpackage

`default_nettype wire

// ### rtl/ccpts_unit_dec.sv
// Purpose: per-unit decode of mode field and selector into a time source
// Assumes: purely combinational, same clock domain as the caller
// Notes:   one instance per unit, registered by the caller
`default_nettype none

module ccpts_unit_dec
  import ccpts_pkg::*;
(
  input  wire logic [ccpts_pkg::MODE_W-1:0] mode,
  input  wire logic [ccpts_pkg::SEL_W-1:0]  sel,
  output ccpts_pkg::ccpts_class_t           cls,
  output logic                              use_sec16,
  output logic [2:0]                        pwm_src,
  output logic                              pwm_rsv
);
  import ccpts_pkg::*;

  // mode field to operating class
  always_comb
  begin
    cls = CCPTS_CLS_RESERVED;
    if (mode == MODE_OFF)
    begin
      cls = CCPTS_CLS_OFF;
    end
    else if (mode[3:2] == 2'h1)
    begin
      // edge counts: falling, rising, every 4th, every 16th
      cls = CCPTS_CLS_CAPTURE; // RULE8
    end
    else if (mode[3:2] == 2'h2 || mode == MODE_CMP_TOGGLE)
    begin
      cls = CCPTS_CLS_COMPARE; // RULE8
    end
    else if (mode[3:2] == 2'h3)
    begin
      cls = CCPTS_CLS_PWM; // RULE8
    end
  end

  // selector to time source
  always_comb
  begin
    use_sec16 = 1'b0;
    pwm_src   = 3'h0;
    pwm_rsv   = 1'b0;
    case (cls)
      CCPTS_CLS_CAPTURE, CCPTS_CLS_COMPARE:
      begin
        // high bit is a don't-care here
        use_sec16 = sel[0]; // RULE2 RULE3
      end
      CCPTS_CLS_PWM:
      begin
        case (sel)
          PWM_SEL_FIRST:  pwm_src = 3'h1; // RULE7
          PWM_SEL_SECOND: pwm_src = 3'h2; // RULE5
          PWM_SEL_THIRD:  pwm_src = 3'h4; // RULE4
          default:        pwm_rsv = 1'b1; // RULE6
        endcase
      end
      default:
      begin
        use_sec16 = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### rtl/ccpts_top.sv
// Purpose: timer source selection for four capture/compare/pwm units
// Assumes: mode fields and timers arrive on mclk, no synchronising needed
// Notes:   time base outputs lag their inputs by one clock
`default_nettype none

module ccpts_top
  import ccpts_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // unit mode fields, unit n at bits 4n-1:4n-4
  input  wire logic [15:0] unit_mode,
  // timer values and period match pulses
  input  wire logic [15:0] first_16bit_timer,
  input  wire logic [15:0] second_16bit_timer,
  input  wire logic [7:0]  first_8bit_period_timer,
  input  wire logic [7:0]  second_8bit_period_timer,
  input  wire logic [7:0]  third_8bit_period_timer,
  input  wire logic [2:0]  period_match,
  // per-unit results, unit n at the n-th slice
  output logic [63:0]      unit_time_base,
  output logic [3:0]       unit_period_tick,
  output logic [3:0]       unit_pwm_rsv,
  output logic [7:0]       unit_timer_sel
);
  import ccpts_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [7:0]       sel;    // selector register
    logic [7:0]       rdata;  // read data, one cycle after strobe
    logic [3:0][15:0] tbase;  // registered time base per unit
    logic [3:0]       tick;   // registered period tick per unit
    logic [3:0]       rsv;    // sticky reserved-code flags
  } ccpts_state_t;

  ccpts_state_t s;            // present state
  ccpts_state_t next_s;       // next state

  // decoder results
  ccpts_class_t cls [NUM_UNITS];   // class per unit
  logic [3:0]   use_sec16;         // 16-bit timer choice
  logic [3:0]   pwm_rsv;           // reserved pwm code live
  logic [2:0]   pwm_src [NUM_UNITS]; // one-hot period timer
  logic [3:0]   is_pwm;            // unit runs pwm
  logic [3:0]   is_cc;             // unit runs capture/compare

  // gathered status bytes for reads
  logic [7:0]   class_byte;
  logic [7:0]   src_byte;

  // one decoder per unit
  generate
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit
      // each unit owns two adjacent selector bits
      ccpts_unit_dec u_dec (
        .mode      (unit_mode[MODE_W*u +: MODE_W]),
        .sel       (s.sel[SEL_W*u +: SEL_W]), // RULE1
        .cls       (cls[u]),
        .use_sec16 (use_sec16[u]),
        .pwm_src   (pwm_src[u]),
        .pwm_rsv   (pwm_rsv[u])
      );
      assign is_pwm[u] = (cls[u] == CCPTS_CLS_PWM);
      assign is_cc[u]  = (cls[u] == CCPTS_CLS_CAPTURE) ||
                         (cls[u] == CCPTS_CLS_COMPARE);
    end
  endgenerate

  // status bytes, two four-unit fields fill all eight bits of each byte
  // second-timer bits are gated by class so a pwm unit's low bit reads as zero
  always_comb
  begin
    class_byte = 8'h00;
    src_byte   = 8'h00;
    class_byte[CLASS_PWM_LSB +: 4] = is_pwm;
    class_byte[CLASS_CC_LSB +: 4]  = is_cc;
    src_byte[SRC_SEC_LSB +: 4]     = use_sec16 & is_cc;
    src_byte[SRC_RSV_LSB +: 4]     = s.rsv;
  end

  // next-state logic
  always_comb
  begin
    next_s = s;

    // selector write; whole byte, every bit writable
    if (reg_wr && reg_addr == OFS_SEL)
    begin
      next_s.sel = reg_wdata; // RULE1
    end

    // reserved flags: write one clears, a live hit wins over the clear
    if (reg_wr && reg_addr == OFS_SRC)
    begin
      next_s.rsv = s.rsv & ~reg_wdata[SRC_RSV_LSB +: 4];
    end
    next_s.rsv = next_s.rsv | pwm_rsv; // RULE6

    // read data stands only in the cycle after the strobe
    // zero outside that cycle lets a bus mux simply or its slaves together
    next_s.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_SEL:   next_s.rdata = s.sel;
        OFS_CLASS: next_s.rdata = class_byte;
        OFS_SRC:   next_s.rdata = src_byte;
        default:   next_s.rdata = 8'h00;  // unmapped reads zero
      endcase
    end

    // time base routing per unit
    // every unit defaults to zero so an idle unit never shows a stale timer
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      next_s.tbase[u] = 16'h0000;
      next_s.tick[u]  = 1'b0;
      if (is_cc[u])
      begin
        // 16-bit timers carry no period tick
        if (use_sec16[u])
        begin
          next_s.tbase[u] = second_16bit_timer; // RULE2
        end
        else
        begin
          next_s.tbase[u] = first_16bit_timer; // RULE3
        end
      end
      else if (is_pwm[u])
      begin
        // one-hot source; reserved code leaves both zero
        case (pwm_src[u])
          3'h1:
          begin
            next_s.tbase[u] = {8'h00, first_8bit_period_timer}; // RULE7
            next_s.tick[u]  = period_match[0]; // RULE7
          end
          3'h2:
          begin
            next_s.tbase[u] = {8'h00, second_8bit_period_timer}; // RULE5
            next_s.tick[u]  = period_match[1]; // RULE5
          end
          3'h4:
          begin
            next_s.tbase[u] = {8'h00, third_8bit_period_timer}; // RULE4
            next_s.tick[u]  = period_match[2]; // RULE4
          end
          default:
          begin
            // no defined timer: hold the unit at zero
            next_s.tbase[u] = 16'h0000; // RULE6
          end
        endcase
      end
    end
  end

  // state register
  // one flop bank for the whole struct keeps reset in a single place
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s       <= '0;
      s.sel   <= SEL_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign reg_rdata        = s.rdata;
  assign unit_time_base   = s.tbase;
  assign unit_period_tick = s.tick;
  assign unit_pwm_rsv     = s.rsv;
  assign unit_timer_sel   = s.sel;

  // checks
  // assertions sleep while rst is high; reset values are compared by the bench
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_SEL_WRITE: assert property ( // RULE1
    reg_wr && reg_addr == OFS_SEL |=> unit_timer_sel == $past(reg_wdata))
    else $error("selector byte not stored");

  AST_SEL_READBACK: assert property ( // RULE1
    reg_rd && reg_addr == OFS_SEL |=> reg_rdata == $past(unit_timer_sel))
    else $error("selector readback wrong");

  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  // status reads return what the units were doing in the strobe cycle
  AST_CLASS_READ: assert property ( // RULE8
    reg_rd && reg_addr == OFS_CLASS |=>
    reg_rdata[CLASS_PWM_LSB +: 4] == $past(is_pwm) &&
    reg_rdata[CLASS_CC_LSB +: 4] == $past(is_cc))
    else $error("mode class readback wrong");

  // second-timer bits only count for capture/compare units
  AST_SRC_READ: assert property ( // RULE2
    reg_rd && reg_addr == OFS_SRC |=>
    reg_rdata[SRC_SEC_LSB +: 4] == $past(use_sec16 & is_cc) &&
    reg_rdata[SRC_RSV_LSB +: 4] == $past(unit_pwm_rsv))
    else $error("source status readback wrong");

  // anything above the last register reads as zero
  AST_UNMAPPED_READ: assert property ( // RULE1
    reg_rd && reg_addr > OFS_SRC |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // a live reserved code always leaves its flag set, even against a clear
  AST_RSV_SET: assert property ( // RULE6
    pwm_rsv != 4'h0 |=> (unit_pwm_rsv & $past(pwm_rsv)) == $past(pwm_rsv))
    else $error("reserved code lost its flag");

  // flags only fall through a write to the status byte
  AST_RSV_HOLD: assert property ( // RULE6
    !(reg_wr && reg_addr == OFS_SRC) |=>
    (unit_pwm_rsv & $past(unit_pwm_rsv)) == $past(unit_pwm_rsv))
    else $error("reserved flag dropped without a clear");

  generate
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_chk
      AST_CC_SECOND: assert property ( // RULE2
        is_cc[u] && s.sel[SEL_W*u] |=>
        unit_time_base[16*u +: 16] == $past(second_16bit_timer))
        else $error("capture/compare not on second 16-bit timer");

      AST_CC_FIRST: assert property ( // RULE3
        is_cc[u] && !s.sel[SEL_W*u] |=>
        unit_time_base[16*u +: 16] == $past(first_16bit_timer) &&
        !unit_period_tick[u])
        else $error("capture/compare not on first 16-bit timer");

      AST_PWM_THIRD: assert property ( // RULE4
        is_pwm[u] && s.sel[SEL_W*u +: SEL_W] == PWM_SEL_THIRD |=>
        unit_time_base[16*u +: 16] == {8'h00, $past(third_8bit_period_timer)} &&
        unit_period_tick[u] == $past(period_match[2]))
        else $error("pwm not on third period timer");

      AST_PWM_SECOND: assert property ( // RULE5
        is_pwm[u] && s.sel[SEL_W*u +: SEL_W] == PWM_SEL_SECOND |=>
        unit_time_base[16*u +: 16] == {8'h00, $past(second_8bit_period_timer)} &&
        unit_period_tick[u] == $past(period_match[1]))
        else $error("pwm not on second period timer");

      AST_PWM_FIRST: assert property ( // RULE7
        is_pwm[u] && s.sel[SEL_W*u +: SEL_W] == PWM_SEL_FIRST |=>
        unit_time_base[16*u +: 16] == {8'h00, $past(first_8bit_period_timer)} &&
        unit_period_tick[u] == $past(period_match[0]))
        else $error("pwm not on first period timer");

      AST_MODE_CLASS: assert property ( // RULE8
        unit_mode[4*u+3 -: 2] == 2'h1 |-> cls[u] == CCPTS_CLS_CAPTURE)
        else $error("capture code not decoded as capture");

      AST_RSV_FLAG: assert property ( // RULE6
        is_pwm[u] && s.sel[SEL_W*u +: SEL_W] == PWM_SEL_RSV |=>
        unit_pwm_rsv[u] && unit_time_base[16*u +: 16] == 16'h0000)
        else $error("reserved pwm code not flagged");

      // units that are off or in a reserved mode get no time base at all
      AST_OFF_ZERO: assert property ( // RULE8
        !is_cc[u] && !is_pwm[u] |=>
        unit_time_base[16*u +: 16] == 16'h0000 && !unit_period_tick[u])
        else $error("idle unit drives a time base");

      // compare codes, the toggle code included, decode as compare
      AST_MODE_COMPARE: assert property ( // RULE8
        unit_mode[4*u+3 -: 2] == 2'h2 || unit_mode[4*u +: 4] == MODE_CMP_TOGGLE |->
        cls[u] == CCPTS_CLS_COMPARE)
        else $error("compare code not decoded as compare");

      // the whole upper quarter of the mode space is pwm
      AST_MODE_PWM: assert property ( // RULE8
        unit_mode[4*u+3 -: 2] == 2'h3 |-> cls[u] == CCPTS_CLS_PWM)
        else $error("pwm code not decoded as pwm");

      // 16-bit timers have no period, so capture/compare never ticks
      AST_CC_NO_TICK: assert property ( // RULE2
        is_cc[u] |=> !unit_period_tick[u])
        else $error("capture/compare unit shows a period tick");

      // a reserved pwm code has no timer, so it has no period tick either
      AST_RSV_NO_TICK: assert property ( // RULE6
        pwm_rsv[u] |=> !unit_period_tick[u])
        else $error("reserved pwm code shows a period tick");
    end
  endgenerate

  // main scenarios
  COV_CC_SECOND: cover property (is_cc[0] && s.sel[0] ##1 is_cc[0]);
  COV_PWM_THIRD: cover property (is_pwm[1] && s.sel[3:2] == PWM_SEL_THIRD);
  COV_RSV_CLEAR: cover property (unit_pwm_rsv[0] ##1 !unit_pwm_rsv[0]);
  COV_PWM_TICK:  cover property (is_pwm[0] && period_match[0] ##1 unit_period_tick[0]);
  COV_RSV_KEPT:  cover property (pwm_rsv[0] && reg_wr && reg_addr == OFS_SRC ##1 unit_pwm_rsv[0]);

endmodule

`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the timer source select block
// Assumes: one 100 ns clock, synchronous active-high reset held ten cycles
// Notes:   timers hold distinct values, xored with the mode index per mode, so every source is told apart
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccpts_pkg::*;

  localparam logic [15:0] T16A = 16'h1234;   // first wide timer value
  localparam logic [15:0] T16B = 16'hABCD;   // second wide timer value
  localparam logic [7:0]  T8A  = 8'h11;      // first period timer value
  localparam logic [7:0]  T8B  = 8'h22;      // second period timer value
  localparam logic [7:0]  T8C  = 8'h33;      // third period timer value
  localparam logic [2:0]  PM   = 3'h5;       // period match pattern, middle one low

  logic        mclk;         // system clock
  logic        rst;          // synchronous reset
  logic [7:0]  reg_addr;     // register address
  logic [7:0]  reg_wdata;    // write data
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [7:0]  reg_rdata;    // read data
  logic [15:0] unit_mode;    // mode fields of all units
  logic [63:0] unit_time_base;
  logic [3:0]  unit_period_tick;
  logic [3:0]  unit_pwm_rsv;
  logic [7:0]  unit_timer_sel;
  logic [2:0]  period_match;
  int          err_count;    // mismatches
  int          tests_run;    // comparisons
  int          cyc;          // watchdog count
  logic [7:0]  rv;           // last read value
  logic [7:0]  sb;           // selector byte under test
  logic        pw;           // mode under test is pwm
  logic [15:0] t16a;         // first wide timer, varied per mode
  logic [15:0] t16b;         // second wide timer
  logic [7:0]  t8a;          // first period timer
  logic [7:0]  t8b;          // second period timer
  logic [7:0]  t8c;          // third period timer
  logic [3:0]  modes [6] = '{4'h4, 4'h7, 4'h8, 4'h2, 4'hC, 4'hF};

  ccpts_top dut_u (
    .mclk                     (mclk),
    .rst                      (rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .unit_mode                (unit_mode),
    .first_16bit_timer        (t16a),
    .second_16bit_timer       (t16b),
    .first_8bit_period_timer  (t8a),
    .second_8bit_period_timer (t8b),
    .third_8bit_period_timer  (t8c),
    .period_match             (period_match),
    .unit_time_base           (unit_time_base),
    .unit_period_tick         (unit_period_tick),
    .unit_pwm_rsv             (unit_pwm_rsv),
    .unit_timer_sel           (unit_timer_sel)
  );

  // free-running clock, 100 ns period
  always #50 mclk = ~mclk;

  // watchdog: a hang counts as a mismatch and ends the run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      results();
    end
  end

  // verdict in one place
  task automatic results();
    $display("counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // compare seen against expected, four-state exact
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write strobe, launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // let a selector or mode change reach the registered outputs
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // expected time base from the unit class and its selector code
  function automatic logic [15:0] exp_base(input logic pwm, input logic [1:0] c);
    if (!pwm)
      return c[0] ? t16b : t16a;
    case (c)
      2'h0:    return {8'h00, t8a};
      2'h1:    return {8'h00, t8b};
      2'h2:    return {8'h00, t8c};
      default: return 16'h0000;   // reserved code gives no base
    endcase
  endfunction

  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    unit_mode = 16'h0000;
    period_match = PM;
    pw = 1'b0;
    {t16a, t16b, t8a, t8b, t8c} = {T16A, T16B, T8A, T8B, T8C};
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // reset state and read-back, one idle cycle before each strobe
    rd(OFS_SEL, rv);
    chk("sel reset", {8'h00, rv}, 16'h0000);
    wr(OFS_SEL, 8'h9C);
    rd(OFS_SEL, rv);
    chk("sel readback", {8'h00, rv}, 16'h009C);
    settle();
    chk("rdata idle", {8'h00, reg_rdata}, 16'h0000);
    chk("sel copy", {8'h00, unit_timer_sel}, 16'h009C);
    $display("test registers done");
    // capture, compare and pwm modes against every selector code, each unit a different code
    foreach (modes[m])
    begin
      @(posedge mclk);
      unit_mode <= {4{modes[m]}};
      {t16a, t16b, t8a, t8b, t8c} <= {T16A, T16B, T8A, T8B, T8C} ^ {7{8'(m)}};
      pw = (modes[m][3:2] == 2'h3);   // only 11xx is pwm; 10xx is compare
      for (int c = 0; c < 4; c++)
      begin
        for (int n = 0; n < 4; n++)
          sb[2*n +: 2] = 2'(c + n);
        wr(OFS_SEL, sb);
        settle();
        for (int n = 0; n < 4; n++)
        begin
          chk("time base", unit_time_base[16*n +: 16],
              exp_base(pw, sb[2*n +: 2]));
          chk("tick", {15'h0, unit_period_tick[n]},
              {15'h0, pw && sb[2*n +: 2] != 2'h3 && PM[sb[2*n +: 2]]});
        end
        rd(OFS_SRC, rv);
        chk("second wide", {12'h0, rv[3:0]},
            {12'h0, pw ? 4'h0 : {sb[6], sb[4], sb[2], sb[0]}});
      end
      rd(OFS_CLASS, rv);
      chk("class", {8'h00, rv}, pw ? 16'h000F : 16'h00F0);
    end
    $display("test source select done");
    // reserved pwm code leaves sticky flags; clear them once the condition is gone
    @(posedge mclk);
    unit_mode <= 16'h3101;   // off and reserved mode codes give no time base
    settle();
    for (int n = 0; n < 4; n++)
      chk("base when off", unit_time_base[16*n +: 16], 16'h0000);
    chk("rsv sticky", {12'h0, unit_pwm_rsv}, 16'h000F);
    wr(OFS_SRC, 8'hF0);
    settle();
    chk("rsv cleared", {12'h0, unit_pwm_rsv}, 16'h0000);
    // read-only and unmapped places leave the selector alone
    wr(OFS_CLASS, 8'hFF);
    wr(8'h40, 8'h55);
    rd(OFS_CLASS, rv);
    chk("class ro", {8'h00, rv}, 16'h0000);
    rd(8'h40, rv);
    chk("unmapped", {8'h00, rv}, 16'h0000);
    chk("sel kept", {8'h00, unit_timer_sel}, {8'h00, sb});
    // a live reserved code beats the write-one clear in the same cycle
    @(posedge mclk);
    unit_mode <= 16'h000C;   // unit 1 in pwm, its selector code is 11
    settle();
    wr(OFS_SRC, 8'hF0);
    settle();
    chk("rsv set wins", {12'h0, unit_pwm_rsv}, 16'h0001);
    chk("rsv base", unit_time_base[15:0], 16'h0000);
    $display("test reserved and unmapped done");
    results();
  end
endmodule

`default_nettype wire
